// *** shared/scra_pkg.sv ***
/*
 Constants, state types and shared helpers for both ends of the serial
 read attention link.
 Assumes a single 100 MHz system clock on each end.
*/
package scra_pkg;

  // Read address byte: seven-bit address zero with the read bit set
  localparam logic [7:0] SCRA_RD_ADDR   = 8'h01;
  localparam logic [7:0] SCRA_NULL_BYTE = 8'h00;

  // Clocks per byte and the clock numbers N-1 and N in each mode
  localparam logic [3:0] SCRA_I2C_CLKS = 4'h9;
  localparam logic [3:0] SCRA_SPI_CLKS = 4'h8;
  localparam logic [3:0] SCRA_I2C_NM1  = 4'h8;
  localparam logic [3:0] SCRA_SPI_NM1  = 4'h7;
  localparam logic [3:0] SCRA_DATA_BITS = 4'h8;

  // Link clock made by the host divider
  localparam int SCRA_SYS_MHZ     = 100;
  localparam int SCRA_LINK_PER_NS = 160;
  localparam int SCRA_HALF_CYC    = SCRA_LINK_PER_NS * SCRA_SYS_MHZ / 2000;

  // Response length is taken from the low opcode bits
  localparam logic [7:0] SCRA_LEN_MASK = 8'h0f;
  localparam logic [7:0] SCRA_LEN_ONE  = 8'h01;

  typedef enum logic [1:0] {D_IDLE, D_ADDR, D_DATA} scra_dev_st_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} scra_host_st_t;

  function automatic logic [3:0] scra_byte_clks(input logic spi);
    return spi ? SCRA_SPI_CLKS : SCRA_I2C_CLKS;
  endfunction : scra_byte_clks

  function automatic logic [3:0] scra_nm1(input logic spi);
    return spi ? SCRA_SPI_NM1 : SCRA_I2C_NM1;
  endfunction : scra_nm1

  function automatic logic [7:0] scra_resp_len(input logic [7:0] op);
    return (op & SCRA_LEN_MASK) + SCRA_LEN_ONE;
  endfunction : scra_resp_len

endpackage : scra_pkg

// *** shared/scra_link_if.sv ***
/*
 Link between the device end and the host end: clock, select, open-drain
 data line and the active-low attention line.
 Assumes a pull-up on the data line; the wired level is resolved here.
*/
`timescale 1ns/1ps
interface scra_link_if;
  logic control_port_clock;
  logic port_select_n;
  logic data_host_out;
  logic data_host_oe;
  logic data_dev_out;
  logic data_dev_oe;
  logic host_attention_line_n;
  logic control_port_data_line;

  // Open drain with pull-up
  assign control_port_data_line =
    !((data_host_oe && !data_host_out) || (data_dev_oe && !data_dev_out));

  modport dev (
    input  control_port_clock,
    input  port_select_n,
    input  control_port_data_line,
    output data_dev_out,
    output data_dev_oe,
    output host_attention_line_n
  );

  modport host (
    output control_port_clock,
    output port_select_n,
    output data_host_out,
    output data_host_oe,
    input  control_port_data_line,
    input  host_attention_line_n
  );
endinterface : scra_link_if

// *** hdl/scra_dev_end.sv ***
/*
 Device end: shifts queued message bytes out over the serial control port
 and drives the active-low attention line with its end-of-read timing.
 Assumes the link pins are asynchronous and are sampled by this clock.
*/
// Behaviour
// R1: Solicited mode: attention only after read request
// R2: Host reads until attention returns high
// R3: Solicited: stays high until next read request
// R4: Unsolicited enabled: attention low whenever message queued
// R5: Queued before N-1: stays low, read continues
// R6: Queued between N-1 and N: one-clock high pulse
// R7: Low held until rising edge N-1
// R8: High until edge N; falls only if queued
// R9: I2C: N-1 is D0, N is NACK
// R10: SPI: N-1 is D1, N is D0
// R11: Host samples attention at falling edge N-1
// R12: Continuing after pulse yields one null byte
// R13: Responses never start null; host drops null opcode
// R14: Host reads length given by opcode
// R15: Stop after pulse: no null byte
// R16: Null byte precedes unsolicited message when continuing
// R17: Per-byte host skips one null opcode byte
// R18: I2C read starts with start, address 0x01
// R19: Host ACKs while low, then NACK, stop
// R20: Attention high after reset until message queued
`timescale 1ns/1ps
module scra_dev_end
  import scra_pkg::*;
(
  // System
  input  wire logic       clock,
  input  wire logic       reset,
  // Configuration
  input  wire logic       spi_mode,
  input  wire logic       unsol_en,
  // Read request command seen by the core
  input  wire logic       read_request,
  // Outgoing message bytes
  input  wire logic       msg_valid,
  input  wire logic [7:0] msg_data,
  input  wire logic       msg_last,
  output logic            msg_take,
  // Link
  scra_link_if.dev        link
);

  logic         scl_m_r, scl_s_r, scl_p_r;
  logic         sda_m_r, sda_s_r, sda_p_r;
  logic         csn_m_r, csn_s_r, csn_p_r;
  scra_dev_st_t st_r;
  logic [3:0]   cnt_r;
  logic [7:0]   shift_r;
  logic         oe_r;
  logic         final_r;
  logic         take_r;
  logic         attn_r;
  logic         raised_r;
  logic         null_r;
  logic         armed_r;

  logic         rise, fall, sel_start, sel_stop;
  logic         i2c_start, i2c_stop, pend, load_now, drop_evt;
  logic [3:0]   clk_no, blen, nm1;
  logic [7:0]   nb;

  // Two-stage synchronisers, then a third stage for edges
  always_ff @(posedge clock) begin
    if (reset) begin
      {scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
      {csn_m_r, csn_s_r, csn_p_r} <= 3'h7;
    end else begin
      {scl_m_r, scl_s_r, scl_p_r} <=
        {link.control_port_clock, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_p_r} <=
        {link.control_port_data_line, sda_m_r, sda_s_r};
      {csn_m_r, csn_s_r, csn_p_r} <= {link.port_select_n, csn_m_r, csn_s_r};
    end
  end

  assign rise      = scl_s_r & ~scl_p_r;
  assign fall      = ~scl_s_r & scl_p_r;
  assign i2c_start = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign i2c_stop  = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
  assign sel_start = spi_mode ? (csn_p_r & ~csn_s_r) : i2c_start;
  assign sel_stop  = spi_mode ? (~csn_p_r & csn_s_r) : i2c_stop;
  assign blen      = scra_byte_clks(spi_mode);
  assign nm1       = scra_nm1(spi_mode); // R9 R10
  assign clk_no    = cnt_r + 4'h1;
  assign pend      = msg_valid & (armed_r | unsol_en); // R1 R4

  // Byte boundary: next byte goes into the shift register
  always_comb begin
    load_now = 1'b0;
    if (fall && !sel_stop && !sel_start) begin
      if (st_r == D_ADDR) begin
        load_now = (cnt_r == SCRA_SPI_CLKS && spi_mode &&
                    shift_r == SCRA_RD_ADDR) ||
                   (cnt_r == SCRA_I2C_CLKS && !spi_mode);
      end else if (st_r == D_DATA) begin
        load_now = (cnt_r == blen);
      end
    end
  end

  // Null byte when a read runs on across the pulse or no message is queued
  assign nb = (null_r || !msg_valid) ? SCRA_NULL_BYTE : msg_data; // R12 R16

  // Attention rises at N-1 of the final byte with nothing queued
  assign drop_evt = (st_r == D_DATA) && rise && clk_no == nm1 &&
                    final_r && !pend; // R5 R7

  // Link state, bit counter and shift register
  always_ff @(posedge clock) begin
    if (reset) begin
      st_r    <= D_IDLE;
      cnt_r   <= 4'h0;
      shift_r <= SCRA_NULL_BYTE;
      oe_r    <= 1'b0;
      final_r <= 1'b0;
      take_r  <= 1'b0;
    end else begin
      take_r <= 1'b0;
      if (sel_stop) begin
        st_r <= D_IDLE;
        oe_r <= 1'b0;
      end else if (sel_start) begin
        st_r  <= D_ADDR;
        cnt_r <= 4'h0;
        oe_r  <= 1'b0;
      end else if (load_now) begin
        st_r    <= D_DATA;
        cnt_r   <= 4'h0;
        shift_r <= nb; // R13 R15
        oe_r    <= ~nb[7];
        final_r <= null_r ? 1'b0 : (msg_valid ? msg_last : 1'b1);
        take_r  <= !null_r && msg_valid;
      end else begin
        case (st_r)
          D_ADDR: begin
            if (rise) begin
              cnt_r <= clk_no;
              if (cnt_r < SCRA_DATA_BITS) begin
                shift_r <= {shift_r[6:0], sda_s_r};
              end
            end else if (fall && cnt_r == SCRA_DATA_BITS) begin
              if (shift_r != SCRA_RD_ADDR) begin
                st_r <= D_IDLE;
              end else if (!spi_mode) begin
                oe_r <= 1'b1;
              end
            end
          end
          D_DATA: begin
            if (rise) begin
              cnt_r <= clk_no;
              if (!spi_mode && clk_no == SCRA_I2C_CLKS && sda_s_r) begin
                st_r <= D_IDLE;
              end
            end else if (fall) begin
              if (cnt_r < SCRA_DATA_BITS) begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_r    <= ~shift_r[6];
              end else begin
                oe_r <= 1'b0;
              end
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Attention line, high pulse and null insertion
  always_ff @(posedge clock) begin
    if (reset) begin
      attn_r   <= 1'b1; // R20
      raised_r <= 1'b0;
      null_r   <= 1'b0;
    end else begin
      if (sel_stop) begin
        null_r   <= 1'b0; // R15
        raised_r <= 1'b0;
      end else if (load_now && null_r) begin
        null_r <= 1'b0;
      end else if (drop_evt) begin
        attn_r   <= 1'b1; // R7
        raised_r <= 1'b1;
      end else if (st_r == D_DATA && rise && clk_no == blen && raised_r) begin
        raised_r <= 1'b0;
        if (pend) begin
          attn_r <= 1'b0; // R6 R8
          null_r <= 1'b1; // R12 R16
        end
      end else if (st_r == D_IDLE) begin
        attn_r <= ~pend; // R1 R3 R4
      end
    end
  end

  // Read request arms solicited replies until attention rises
  always_ff @(posedge clock) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (read_request) begin
      armed_r <= 1'b1;
    end else if (drop_evt) begin
      armed_r <= 1'b0; // R3
    end
  end

  assign msg_take                   = take_r;
  assign link.data_dev_out          = 1'b0;
  assign link.data_dev_oe           = oe_r;
  assign link.host_attention_line_n = attn_r;

endmodule : scra_dev_end

// *** hdl/scra_host_end.sv ***
/*
 Host end: makes the link clock, reads while attention is low, samples
 attention at clock N-1 and hands whole responses to its user.
 Assumes the data and attention pins are asynchronous to this clock.
*/
`timescale 1ns/1ps
module scra_host_end
  import scra_pkg::*;
(
  // System
  input  wire logic       clock,
  input  wire logic       reset,
  // Configuration
  input  wire logic       spi_mode,
  // Received response bytes
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_opcode,
  // Link
  scra_link_if.host       link
);

  localparam int          DIV_W = 8;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCRA_HALF_CYC - 1);

  logic [DIV_W-1:0] div_r;
  logic             tick;
  logic             sda_m_r, sda_s_r, att_m_r, att_s_r;
  scra_host_st_t    st_r;
  logic [1:0]       step_r;
  logic [3:0]       bit_r;
  logic             addr_r, cont_r, scl_r, csn_r, oe_r;
  logic [7:0]       sr_r;
  logic [7:0]       remain_r;
  logic             rxv_r, rxo_r;
  logic [7:0]       rxd_r;
  logic             cont_new, byte_done;
  logic [3:0]       blen, nm1, nxt;
  logic [7:0]       rx_b;

  function automatic logic drv(input logic [3:0] k, input logic is_addr,
                               input logic cont, input logic spi);
    logic [7:0] sh;
    sh = SCRA_RD_ADDR << (k - 4'h1);
    if (is_addr) begin
      return (k <= SCRA_DATA_BITS) ? ~sh[7] : 1'b0; // R18
    end
    return !spi && k == SCRA_I2C_CLKS && cont; // R19
  endfunction : drv

  always_ff @(posedge clock) begin
    if (reset) begin
      div_r <= '0;
    end else begin
      div_r <= (div_r == HALF_LAST) ? '0 : div_r + DIV_W'(1);
    end
  end
  assign tick = (div_r == HALF_LAST);

  always_ff @(posedge clock) begin
    if (reset) begin
      {sda_m_r, sda_s_r, att_m_r, att_s_r} <= 4'hf;
    end else begin
      {sda_m_r, sda_s_r} <= {link.control_port_data_line, sda_m_r};
      {att_m_r, att_s_r} <= {link.host_attention_line_n, att_m_r};
    end
  end

  assign blen     = scra_byte_clks(spi_mode);
  assign nm1      = scra_nm1(spi_mode);
  assign cont_new = (!addr_r && bit_r == nm1) ? ~att_s_r : cont_r; // R11 R5
  assign nxt      = (bit_r == blen) ? 4'h1 : bit_r + 4'h1;
  assign byte_done = tick && st_r == H_BIT && !scl_r && !addr_r &&
                     bit_r == SCRA_DATA_BITS;
  assign rx_b     = {sr_r[6:0], sda_s_r};

  // Read sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      st_r   <= H_IDLE;
      step_r <= 2'h0;
      bit_r  <= 4'h1;
      addr_r <= 1'b1;
      cont_r <= 1'b1;
      scl_r  <= 1'b1;
      csn_r  <= 1'b1;
      oe_r   <= 1'b0;
      sr_r   <= SCRA_NULL_BYTE;
    end else if (tick) begin
      case (st_r)
        H_IDLE: begin
          if (!att_s_r) begin
            st_r   <= H_START; // R2
            step_r <= 2'h0;
          end
        end
        H_START: begin
          step_r <= step_r + 2'h1;
          if (step_r == 2'h0) begin
            if (spi_mode) begin
              csn_r <= 1'b0;
            end else begin
              oe_r <= 1'b1; // R18
            end
          end else begin
            scl_r  <= 1'b0;
            st_r   <= H_BIT;
            bit_r  <= 4'h1;
            addr_r <= 1'b1;
            cont_r <= 1'b1;
            oe_r   <= drv(4'h1, 1'b1, 1'b1, spi_mode);
          end
        end
        H_BIT: begin
          if (scl_r) begin
            scl_r  <= 1'b0;
            cont_r <= cont_new; // R11
            if (bit_r == blen && !addr_r && !cont_r) begin
              st_r   <= H_STOP; // R19
              step_r <= 2'h0;
            end else begin
              bit_r <= nxt;
              if (bit_r == blen) begin
                addr_r <= 1'b0;
              end
              oe_r <= drv(nxt, addr_r && bit_r != blen, cont_new, spi_mode);
            end
          end else begin
            scl_r <= 1'b1;
            if (!addr_r && bit_r <= SCRA_DATA_BITS) begin
              sr_r <= rx_b;
            end
          end
        end
        H_STOP: begin
          step_r <= step_r + 2'h1;
          if (step_r == 2'h0) begin
            oe_r <= ~spi_mode;
          end else if (step_r == 2'h1) begin
            scl_r <= 1'b1;
          end else begin
            csn_r <= 1'b1;
            oe_r  <= 1'b0;
            st_r  <= H_IDLE;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // Response framing by opcode length, null opcode dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      remain_r <= 8'h00;
      rxv_r    <= 1'b0;
      rxo_r    <= 1'b0;
      rxd_r    <= SCRA_NULL_BYTE;
    end else begin
      rxv_r <= 1'b0;
      if (byte_done) begin
        rxd_r <= rx_b;
        if (remain_r == 8'h00) begin
          if (rx_b != SCRA_NULL_BYTE) begin // R13 R17
            rxv_r    <= 1'b1;
            rxo_r    <= 1'b1;
            remain_r <= scra_resp_len(rx_b) - SCRA_LEN_ONE; // R14
          end
        end else begin
          rxv_r    <= 1'b1;
          rxo_r    <= 1'b0;
          remain_r <= remain_r - 8'h01;
        end
      end
    end
  end

  assign rx_valid                = rxv_r;
  assign rx_data                 = rxd_r;
  assign rx_opcode               = rxo_r;
  assign link.control_port_clock = scl_r;
  assign link.port_select_n      = csn_r;
  assign link.data_host_out      = 1'b0;
  assign link.data_host_oe       = oe_r;

endmodule : scra_host_end

// *** verif/scra_link_asserts.sv ***
/*
 Checker for the link between the two ends: attention timing and levels.
 Assumes raw link signals and the device's user inputs on one clock.
*/
`timescale 1ns/1ps
module scra_link_asserts
  import scra_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic reset,
  // Device user side
  input wire logic spi_mode,
  input wire logic unsol_en,
  input wire logic read_request,
  input wire logic msg_valid,
  // Link
  input wire logic control_port_clock,
  input wire logic port_select_n,
  input wire logic control_port_data_line,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic host_attention_line_n
);
  logic       lclk_q_r;
  logic       data_q_r;
  logic       sel_q_r;
  logic       frame_r;
  logic       req_r;
  logic [3:0] bit_r;
  logic [3:0] age_r;
  logic       lrise;
  logic       hi_both;
  logic       in_frame;
  logic [3:0] clks;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  assign lrise    = control_port_clock && !lclk_q_r;
  assign hi_both  = !spi_mode && control_port_clock && lclk_q_r;
  assign in_frame = spi_mode ? !port_select_n : frame_r;
  assign clks     = spi_mode ? SCRA_SPI_CLKS : SCRA_I2C_CLKS;

  always_ff @(posedge clock) begin
    lclk_q_r <= control_port_clock;
    data_q_r <= control_port_data_line;
    sel_q_r  <= port_select_n;
  end

  // Start opens, stop closes a two-wire frame
  always_ff @(posedge clock) begin
    if (reset)
      frame_r <= 1'b0;
    else if (hi_both && data_q_r && !control_port_data_line)
      frame_r <= 1'b1;
    else if (hi_both && !data_q_r && control_port_data_line)
      frame_r <= 1'b0;
  end

  // Link clock number within the current byte
  always_ff @(posedge clock) begin
    if (reset)
      bit_r <= 4'h0;
    else if (spi_mode ? (sel_q_r && !port_select_n)
                      : (hi_both && data_q_r && !control_port_data_line))
      bit_r <= 4'h0;
    else if (lrise)
      bit_r <= (bit_r == clks) ? 4'h1 : bit_r + 4'h1;
  end

  always_ff @(posedge clock) begin
    if (reset || lrise)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end

  always_ff @(posedge clock) begin
    if (reset)
      req_r <= 1'b0;
    else if (read_request)
      req_r <= 1'b1;
    else if ($rose(host_attention_line_n))
      req_r <= 1'b0;
  end

  chk_reset_idle_link: assert property ($fell(reset) |->
    host_attention_line_n && control_port_clock && port_select_n
    && !data_dev_oe && !data_host_oe) else $error("link not idle");
  chk_rise_spi_nm1: assert property ($rose(host_attention_line_n)
    && spi_mode |-> bit_r == SCRA_SPI_NM1) else $error("bad SPI rise");
  chk_rise_i2c_nm1: assert property ($rose(host_attention_line_n)
    && !spi_mode |-> bit_r == SCRA_I2C_NM1) else $error("bad I2C rise");
  chk_refall_clock_n: assert property ($fell(host_attention_line_n)
    && in_frame |-> bit_r == clks) else $error("refall off clock N");
  chk_high_hold_min: assert property ($rose(host_attention_line_n)
    |=> host_attention_line_n [*8]) else $error("attention pulse short");
  chk_rise_near_edge: assert property ($rose(host_attention_line_n)
    |-> age_r >= 4'h1 && age_r <= 4'h6) else $error("rise off edge");
  chk_unsol_low_idle: assert property (
    (!in_frame && unsol_en && msg_valid) [*6] |-> !host_attention_line_n)
    else $error("queued message not flagged");
  chk_sol_needs_req: assert property ($fell(host_attention_line_n)
    && !unsol_en |-> req_r) else $error("attention without request");
endmodule : scra_link_asserts

// *** verif/serial_read_attention_control_test.sv ***
/*
 Self-checking bench: both ends joined by the link, byte stream model.
 Assumes the host end makes the link clock and reads while flagged.
*/
`timescale 1ns/1ps
module serial_read_attention_control_test
  import scra_pkg::*;
;
  logic        clock        = 1'b0;
  logic        reset        = 1'b1;
  logic        spi_mode     = 1'b0;
  logic        unsol_en     = 1'b0;
  logic        read_request = 1'b0;
  logic        msg_valid    = 1'b0;
  logic [7:0]  msg_data     = 8'h00;
  logic        msg_last     = 1'b0;
  logic        msg_take;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_opcode;
  logic [8:0]  attn9;
  logic [7:0]  mq[$];
  logic        lq[$];
  logic [8:0]  eq[$];
  logic [31:0] seed         = 32'h0000000e;
  int          failures     = 0;
  int          comparisons  = 0;
  int          cycles       = 0;

  scra_link_if scra_link_if_i ();
  scra_dev_end scra_dev_end_i (.clock(clock), .reset(reset),
    .spi_mode(spi_mode), .unsol_en(unsol_en), .read_request(read_request),
    .msg_valid(msg_valid), .msg_data(msg_data), .msg_last(msg_last),
    .msg_take(msg_take), .link(scra_link_if_i.dev));
  scra_host_end scra_host_end_i (.clock(clock), .reset(reset),
    .spi_mode(spi_mode), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_opcode(rx_opcode), .link(scra_link_if_i.host));
  scra_link_asserts scra_link_asserts_i (.clock(clock), .reset(reset),
    .spi_mode(spi_mode), .unsol_en(unsol_en), .read_request(read_request),
    .msg_valid(msg_valid),
    .control_port_clock(scra_link_if_i.control_port_clock),
    .port_select_n(scra_link_if_i.port_select_n),
    .control_port_data_line(scra_link_if_i.control_port_data_line),
    .data_host_oe(scra_link_if_i.data_host_oe),
    .data_dev_oe(scra_link_if_i.data_dev_oe),
    .host_attention_line_n(scra_link_if_i.host_attention_line_n));

  assign attn9 = {8'h00, scra_link_if_i.host_attention_line_n};

  initial begin
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Nonzero opcode, length one to four bytes
  task automatic push_msg();
    logic [7:0] op;
    int         len;
    op  = (rnd() & 8'hf3) | 8'h10;
    len = int'(op[3:0]) + 1;
    for (int k = 0; k < len; k++) begin
      mq.push_back(k == 0 ? op : rnd());
      lq.push_back(k == len - 1);
      eq.push_back({k == 0, mq[$]});
    end
  endtask : push_msg

  task automatic pulse_req();
    @(negedge clock);
    read_request = 1'b1;
    @(negedge clock);
    read_request = 1'b0;
  endtask : pulse_req

  task automatic drain();
    int n;
    n = 0;
    while (eq.size() > 0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    check(9'(eq.size()), 9'h000);
    repeat (60) @(negedge clock);
  endtask : drain

  // Queue head for the device, advanced on each take
  always @(negedge clock) begin
    if (msg_take === 1'b1 && mq.size() > 0) begin
      void'(mq.pop_front());
      void'(lq.pop_front());
    end
    msg_valid = mq.size() > 0;
    msg_data  = msg_valid ? mq[0] : rnd();
    msg_last  = msg_valid ? lq[0] : 1'b0;
  end

  always @(negedge clock) begin
    if (rx_valid === 1'b1)
      check({rx_opcode, rx_data},
            eq.size() > 0 ? eq.pop_front() : ~{rx_opcode, rx_data});
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    for (int m = 0; m < 2; m++) begin
      spi_mode = m[0];
      unsol_en = 1'b0;
      repeat (40) @(negedge clock);
      check(attn9, 9'h001);
      push_msg();
      repeat (100) @(negedge clock);
      check(attn9, 9'h001);
      pulse_req();
      drain();
      push_msg();
      repeat (100) @(negedge clock);
      check(attn9, 9'h001);
      pulse_req();
      drain();
      unsol_en = 1'b1;
      push_msg();
      drain();
      push_msg();
      push_msg();
      drain();
      // Second message lands between clocks N-1 and N of the final byte
      for (int r = 0; r < 3; r++) begin
        push_msg();
        while (mq.size() > 0) @(negedge clock);
        repeat (spi_mode ? SCRA_SPI_NM1 : SCRA_I2C_NM1)
          @(posedge scra_link_if_i.control_port_clock);
        repeat (6 + 2 * r) @(negedge clock);
        push_msg();
        drain();
      end
    end
    tally_and_finish();
  end
endmodule : serial_read_attention_control_test
